// *** design/nst_host.sv ***
// host controller driving the timekeeper RAM pins, with result FIFO
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// result fifo
// ****************************************
module nst_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rd_ptr_r];
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (clk_en) begin
      if (push) begin
        mem[wr_ptr_r] <= in_data;
        wr_ptr_r <= AW'((wr_ptr_r + 1) % D);
      end
      if (pop) begin
        rd_ptr_r <= AW'((rd_ptr_r + 1) % D);
      end
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != (AW+1)'(D));
      out_valid <= (cnt_nxt != '0);
    end
  end
endmodule : nst_fifo

// ****************************************
// host controller
// ****************************************
// How it works
// - host keeps address steady across every write cycle
// - write-enable stays high for recovery time before next cycle
// - host keeps output-enable high during writes
// - unlock by 64-bit pattern, one bit per write on data bit 0
// - any read resets comparison pointer to first bit
// - unlock writes also store into RAM; use one scratch address
// - eight BCD registers, bit 0 of reg 0 through bit 7 of reg 7
// - host moves each timekeeper register as a whole byte
// - pattern is C5 3A A3 5C twice, each byte lsb first
module nst_host (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire nst_pkg::nst_op_t cmd_op,
  input wire logic [nst_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [nst_pkg::DATA_W-1:0] cmd_data,
  input wire logic [63:0] cmd_time,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [nst_pkg::DATA_W-1:0] rsp_data,
  input wire logic pwr_fail,
  output logic [nst_pkg::ADDR_W-1:0] address_lines,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic tk_rst_n,
  output logic [nst_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [nst_pkg::DATA_W-1:0] dq_i
);
  import nst_pkg::*;

  nst_state_t state_r;
  nst_op_t op_r;
  logic [DATA_W-1:0] data_r;
  logic [63:0] time_r;
  logic [7:0] idx_r;
  logic [4:0] cnt_r;
  logic [DATA_W-1:0] shift_r;
  logic fifo_in_ready;

  // ****************************************
  // per-cycle decode
  // ****************************************
  wire is_clk = op_r[1];
  wire [5:0] bit_sel = 6'(idx_r - IDX_PAT_FIRST);
  wire in_pat = is_clk && (idx_r >= IDX_PAT_FIRST) && (idx_r <= IDX_PAT_LAST);
  wire in_xfer = is_clk && (idx_r >= IDX_XFER_FIRST);
  // idx 0 of a clock op is the pointer-reset read
  wire cyc_rd = is_clk ? ((idx_r == 8'h00) || (in_xfer && op_r == OP_CLK_RD))
                       : (op_r == OP_RAM_RD);
  wire [DATA_W-1:0] cyc_wdata =
    in_pat ? {7'h00, UNLOCK_PAT[bit_sel]} :
    in_xfer ? {7'h00, time_r[bit_sel]} :
    data_r;
  // whole bytes only are handed back
  wire cyc_push = cyc_rd && (op_r == OP_RAM_RD ||
                             (in_xfer && bit_sel[2:0] == 3'h7));
  wire cyc_last = !is_clk || (idx_r == IDX_LAST);
  wire [DATA_W-1:0] shift_nxt = {dq_i[0], shift_r[DATA_W-1:1]};
  wire act_end = (state_r == ST_ACT) && (cnt_r == 5'h01);
  wire fifo_push = act_end && cyc_rd && cyc_push;
  wire [DATA_W-1:0] fifo_data = (op_r == OP_RAM_RD) ? dq_i : shift_nxt;
  // stall before a pushing cycle, never mid-cycle; only we fill it
  wire can_start = !pwr_fail && !(cyc_push && !fifo_in_ready);
  wire accept = cmd_valid && cmd_ready;

  nst_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_data),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp_data)
  );

  // ****************************************
  // bus sequencer
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      op_r <= OP_RAM_RD;
      data_r <= '0;
      time_r <= '0;
      idx_r <= '0;
      cnt_r <= '0;
      shift_r <= '0;
      cmd_ready <= 1'b0;
      address_lines <= '0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      tk_rst_n <= 1'b1;
      dq_o <= '0;
      dq_oe <= 1'b0;
    end else if (clk_en) begin
      case (state_r)
        ST_IDLE: begin
          cmd_ready <= !pwr_fail && !accept;
          if (accept) begin
            op_r <= cmd_op;
            // clock ops use this address as RAM scratch
            address_lines <= cmd_addr;
            data_r <= cmd_data;
            time_r <= cmd_time;
            idx_r <= 8'h00;
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (can_start) begin
            ce_n <= 1'b0;
            oe_n <= !cyc_rd;
            we_n <= cyc_rd;
            dq_o <= cyc_wdata;
            dq_oe <= !cyc_rd;
            cnt_r <= cyc_rd ? ACC_CYC : WP_CYC;
            state_r <= ST_ACT;
          end
        end
        ST_ACT: begin
          cnt_r <= cnt_r - 5'h01;
          if (cnt_r == 5'h01) begin
            if (cyc_rd) begin
              if (in_xfer) begin
                shift_r <= shift_nxt;
              end
              ce_n <= 1'b1;
              oe_n <= 1'b1;
              cnt_r <= OD_CYC;
              state_r <= ST_REC;
            end else begin
              we_n <= 1'b1;
              cnt_r <= DH_CYC;
              state_r <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          cnt_r <= cnt_r - 5'h01;
          if (cnt_r == 5'h01) begin
            ce_n <= 1'b1;
            dq_oe <= 1'b0;
            cnt_r <= WR_CYC;
            state_r <= ST_REC;
          end
        end
        ST_REC: begin
          cnt_r <= cnt_r - 5'h01;
          if (cnt_r == 5'h01) begin
            if (cyc_last) begin
              state_r <= ST_IDLE;
            end else begin
              idx_r <= idx_r + 8'h01;
              state_r <= ST_SETUP;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst || !clk_en);

  property p_oe_off_in_write;
    !we_n |-> oe_n;
  endproperty
  a_oe_off_in_write: assert property (p_oe_off_in_write)
    else $error("output enable low during write");
  property p_addr_steady;
    (!ce_n && $past(!ce_n)) |-> $stable(address_lines);
  endproperty
  a_addr_steady: assert property (p_addr_steady)
    else $error("address moved during a cycle");
  // twelve low samples: eleven would be 88 ns, under the write pulse
  property p_write_width;
    $fell(we_n) |-> (!we_n && !ce_n && dq_oe)[*8] ##1 (!we_n && dq_oe)[*4];
  endproperty
  a_write_width: assert property (p_write_width)
    else $error("write pulse too short");
  property p_recovery;
    $rose(we_n) |-> (!$fell(ce_n) && !$fell(we_n) && dq_oe)[*3]
      ##1 (!$fell(ce_n) && !$fell(we_n))[*3];
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("next cycle before write recovery");
  // fifteen low samples, the full 120 ns before the byte is taken
  property p_read_access;
    $fell(oe_n) |-> (!oe_n && !ce_n && we_n && !dq_oe)[*8] ##1 (!oe_n)[*7];
  endproperty
  a_read_access: assert property (p_read_access)
    else $error("read cycle shorter than access time");
  property p_ptr_reset_read;
    ($fell(ce_n) && is_clk && idx_r == 8'h00) |-> (!oe_n && we_n);
  endproperty
  a_ptr_reset_read: assert property (p_ptr_reset_read)
    else $error("clock op does not open with a read");
  property p_pattern_bit;
    ($fell(ce_n) && in_pat) |-> (!we_n && dq_o[0] == UNLOCK_PAT[bit_sel]);
  endproperty
  a_pattern_bit: assert property (p_pattern_bit)
    else $error("wrong unlock bit or not a write");
  property p_no_cycle_on_fail;
    $fell(ce_n) |-> $past(!pwr_fail);
  endproperty
  a_no_cycle_on_fail: assert property (p_no_cycle_on_fail)
    else $error("bus cycle started during supply fail");
  property p_byte_push;
    (fifo_push && is_clk) |-> (bit_sel[2:0] == 3'h7 && fifo_in_ready);
  endproperty
  a_byte_push: assert property (p_byte_push)
    else $error("partial timekeeper byte pushed");

endmodule : nst_host

`default_nettype wire

// *** design/nst_pkg.sv ***
// constants and types for the host-side timekeeper RAM controller
package nst_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;

  // ****************************************
  // bus timing
  // ****************************************
  localparam int CLK_NS = 8;
  localparam int ADDRESS_ACCESS_TIME_NS = 120;
  localparam int T_WP_NS = 90;
  localparam int T_DH_NS = 20;
  localparam int T_WR_NS = 20;
  localparam int T_OD_NS = 40;
  localparam logic [4:0] ACC_CYC =
    5'((ADDRESS_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] WP_CYC = 5'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] DH_CYC = 5'((T_DH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] WR_CYC = 5'((T_WR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] OD_CYC = 5'((T_OD_NS + CLK_NS - 1) / CLK_NS);

  // ****************************************
  // timekeeper sequence
  // ****************************************
  // bit i is sent in unlock write i: bytes C5 3A A3 5C twice, lsb first
  localparam logic [63:0] UNLOCK_PAT = 64'h5CA3_3AC5_5CA3_3AC5;
  localparam logic [7:0] IDX_PAT_FIRST = 8'h01;
  localparam logic [7:0] IDX_PAT_LAST = 8'h40;
  localparam logic [7:0] IDX_XFER_FIRST = 8'h41;
  localparam logic [7:0] IDX_LAST = 8'h80;

  typedef enum logic [1:0] {
    OP_RAM_RD = 2'h0,
    OP_RAM_WR = 2'h1,
    OP_CLK_RD = 2'h2,
    OP_CLK_WR = 2'h3
  } nst_op_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SETUP = 5'h02,
    ST_ACT   = 5'h04,
    ST_HOLD  = 5'h08,
    ST_REC   = 5'h10
  } nst_state_t;

endpackage : nst_pkg

// *** tb/nst_dev_model.sv ***
// behavioural model of the timekeeper RAM seen from its pins
`timescale 1ns/1ps
`default_nettype none
module nst_dev_model (
  input wire logic ref_clk,
  input wire logic pwr_fail,
  input wire logic [nst_pkg::ADDR_W-1:0] address_lines,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic tk_rst_n,
  input wire logic [nst_pkg::DATA_W-1:0] dq,
  output logic [nst_pkg::DATA_W-1:0] dev_q
);
  import nst_pkg::*;
  logic [7:0] ram [0:2**ADDR_W-1];
  logic [63:0] tk;
  logic [5:0] ptr, xcnt;
  logic unl, miss, wr_q, rd_q;
  logic [7:0] d_r, last;
  // unselected cycles and supply fail are invisible here
  wire logic wr = !pwr_fail && !ce_n && !we_n;
  wire logic rd = !pwr_fail && !ce_n && !oe_n && we_n;
  wire logic [7:0] rd_val = unl ? {7'h00, tk[xcnt]}
    : ram[address_lines];
  // released bus shows the inverse so a stale sample cannot pass
  assign dev_q = rd ? rd_val : ~last;
  initial begin
    tk = 64'h0;
    {ptr, xcnt, unl, miss, wr_q, rd_q, last} = '0;
  end
  always @(posedge ref_clk) begin
    wr_q <= wr;
    rd_q <= rd;
    if (wr) d_r <= dq;
    if (rd) last <= rd_val;
    if (!tk_rst_n && !tk[36]) begin
      unl <= 1'b0;
    end else if (rd_q && !rd) begin
      if (unl) begin
        xcnt <= xcnt + 6'h01;
        if (xcnt == 6'h3F) unl <= 1'b0;
      end else begin
        ptr <= 6'h00;
        miss <= 1'b0;
      end
    end else if (wr_q && !wr) begin
      if (unl) begin
        tk[xcnt] <= d_r[0];
        xcnt <= xcnt + 6'h01;
        if (xcnt == 6'h3F) unl <= 1'b0;
      end else begin
        ram[address_lines] <= d_r;
        if (!miss && d_r[0] == UNLOCK_PAT[ptr]) begin
          ptr <= ptr + 6'h01;
          if (ptr == 6'h3F) begin
            unl <= 1'b1;
            xcnt <= 6'h00;
          end
        end else begin
          miss <= 1'b1;
        end
      end
    end
  end
endmodule : nst_dev_model
`default_nettype wire

// *** tb/nst_host_tb.sv ***
// self-checking bench for the host controller against the device model
`timescale 1ns/1ps
`default_nettype none
module nst_host_tb;
  import nst_pkg::*;
  // valid bcd fields; hours byte is 12-hour mode, pm, eleven
  localparam logic [63:0] TIME_VAL = 64'h2412_0503_B145_3007;
  logic ref_clk, srst, clk_en, cmd_valid, rsp_ready, pwr_fail;
  nst_op_t cmd_op;
  logic [ADDR_W-1:0] cmd_addr, address_lines;
  logic [DATA_W-1:0] cmd_data, rsp_data, dq_o, dev_q;
  logic [63:0] cmd_time;
  logic cmd_ready, rsp_valid, ce_n, oe_n, we_n, tk_rst_n, dq_oe;
  wire logic [DATA_W-1:0] dq_bus = dq_oe ? dq_o : dev_q;
  int fails = 0;
  int compares = 0;

  nst_host i_dut (.ref_clk, .srst, .clk_en, .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_addr, .cmd_data, .cmd_time, .rsp_valid, .rsp_ready,
    .rsp_data, .pwr_fail, .address_lines, .ce_n, .oe_n, .we_n, .tk_rst_n,
    .dq_o, .dq_oe, .dq_i(dq_bus));
  nst_dev_model i_dev (.ref_clk, .pwr_fail, .address_lines, .ce_n, .oe_n,
    .we_n, .tk_rst_n, .dq(dq_bus), .dev_q);

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic summarize();
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %0h got %0h", what, exp, got);
    end
  endtask : chk
  task automatic wait_for(input bit on_rsp);
    int n;
    n = 0;
    while ((on_rsp ? rsp_valid : cmd_ready) !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 5000) begin
        chk("timeout", 64'h0, 64'h1);
        summarize();
      end
    end
  endtask : wait_for
  task automatic cmd(input nst_op_t op, input logic [12:0] a,
                     input logic [7:0] d, input logic [63:0] t);
    wait_for(1'b0);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_time = t;
    cmd_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
  endtask : cmd
  // one-cycle stall after each pop keeps the far side slow
  task automatic pop(input logic [7:0] exp);
    rsp_ready = 1'b1;
    wait_for(1'b1);
    chk("rsp_data", {56'h0, exp}, {56'h0, rsp_data});
    @(posedge ref_clk);
    #1;
    rsp_ready = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : pop

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_ram();
    cmd(OP_RAM_WR, 13'h1FFF, 8'h3C, 64'h0);
    cmd(OP_RAM_WR, 13'h0000, 8'hA5, 64'h0);
    cmd(OP_RAM_RD, 13'h1FFF, 8'h00, 64'h0);
    pop(8'h3C);
    cmd(OP_RAM_RD, 13'h0000, 8'h00, 64'h0);
    pop(8'hA5);
  endtask : t_ram
  task automatic t_clock();
    int n;
    cmd(OP_RAM_WR, 13'h0010, 8'hAA, 64'h0);
    cmd(OP_CLK_WR, 13'h0010, 8'h00, TIME_VAL);
    wait_for(1'b0);
    chk("tk_regs", TIME_VAL, i_dev.tk);
    chk("unlocked", 64'h0, {63'h0, i_dev.unl});
    cmd(OP_RAM_RD, 13'h0010, 8'h00, 64'h0);
    pop({7'h00, UNLOCK_PAT[63]});
    repeat (4) cmd(OP_CLK_RD, 13'h0010, 8'h00, 64'h0);
    // fifo now full: this read must wait with the device deselected
    cmd(OP_RAM_RD, 13'h1FFF, 8'h00, 64'h0);
    n = 0;
    repeat (400) begin
      @(posedge ref_clk);
      #1;
      if (ce_n !== 1'b1) n++;
    end
    chk("ce_n_while_full", 64'h0, 64'(n));
    for (int r = 0; r < 32; r++) pop(TIME_VAL[8*(r%8) +: 8]);
    pop(8'h3C);
  endtask : t_clock
  task automatic t_pwr();
    wait_for(1'b0);
    pwr_fail = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("cmd_ready_pf", 64'h0, {63'h0, cmd_ready});
    pwr_fail = 1'b0;
    cmd(OP_RAM_WR, 13'h0005, 8'h77, 64'h0);
    // supply fails while the taken write waits: no select may follow
    pwr_fail = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("ce_n_pf", 64'h1, {63'h0, ce_n});
    pwr_fail = 1'b0;
    cmd(OP_RAM_RD, 13'h0005, 8'h00, 64'h0);
    // clock enable low must hold the taken read before its select
    clk_en = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    chk("ce_n_frozen", 64'h1, {63'h0, ce_n});
    chk("rsp_valid_frozen", 64'h0, {63'h0, rsp_valid});
    clk_en = 1'b1;
    pop(8'h77);
  endtask : t_pwr

  // ****************************************
  // clock and main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_RAM_RD;
    cmd_addr = '0;
    cmd_data = '0;
    cmd_time = '0;
    clk_en = 1'b1;
    rsp_ready = 1'b0;
    pwr_fail = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    t_ram();
    t_clock();
    t_pwr();
    summarize();
  end
endmodule : nst_host_tb
`default_nettype wire
